// file: common/msrc_regs.svh
// Constants for the mode strap and reset control block.
// Assumes a single 40 MHz SYS_CLK domain; straps are asynchronous board levels.
// Overview of operation
// (RULE_01) Reset input low holds device in reset; high lets it run normally.
// (RULE_02) Outside party holds reset low at least six 20.48 MHz periods.
// (RULE_03) Soft reset register bit 3 resets the device like the pin.
// (RULE_04) Hardware reset returns all serial port registers to defaults.
// (RULE_05) In reset, master host mode stops bit clock and receive frame sync.
// (RULE_06) In reset, line driver terminates low impedance; wake tone detect is blocked.
// (RULE_07) Role select pin high means network termination, low means line termination.
// (RULE_08) Mode byte 8 bit 0 also sets the termination role.
// (RULE_09) Strap pair decodes bus mode, host parallel, or host serial port.
// (RULE_10) Host mode: parallel select high enables 8-bit port, low serial port.
// (RULE_11) Board ties parallel select low whenever host select is low.
// (RULE_12) Host mode: TDM bus carries only 2B+D, control through register port.
// (RULE_13) Host mode offers short, long, bus 2B+D and timeslot formats.
// (RULE_14) Bus mode disables serial port, reuses its pins, all over TDM bus.
// (RULE_15) Line termination: frequency reference pin is an 8 kHz input.
// (RULE_16) Network termination host mode: reference pin drives clock if enabled.
// (RULE_17) Synchronise reset and straps; hold reset until minimum low time counted.
`ifndef MSRC_REGS_SVH
`define MSRC_REGS_SVH
// Minimum reset low time: six oscillator periods, counted in SYS_CLK cycles
`define MSRC_RST_MIN_OSC      6
`define MSRC_OSC_KHZ          20480
`define MSRC_SYS_KHZ          40000
// Rounded up, so a count that is one short can never release the device early
`define MSRC_RST_MIN_CYC      ((`MSRC_RST_MIN_OSC * `MSRC_SYS_KHZ + `MSRC_OSC_KHZ - 1) / `MSRC_OSC_KHZ)
`define MSRC_SOFT_RST_BIT     3
`define MSRC_ROLE_BIT         0
`define MSRC_FMT_SHORT        2'h0
`define MSRC_FMT_LONG         2'h1
`define MSRC_FMT_BUS2BD       2'h2
`define MSRC_FMT_TSA          2'h3
`define MSRC_CNT_W            4
`endif

// file: common/msrc_pkg.sv
// Types for the mode strap and reset control block.
// Assumes msrc_regs.svh supplies the numeric constants.
package msrc_pkg;
    typedef enum logic [1:0] {
        MSRC_BUS_MODE   = 2'h0,
        MSRC_HOST_SER   = 2'h1,
        MSRC_HOST_PAR   = 2'h2
    } msrc_mode_type;
    typedef enum logic [1:0] {
        MSRC_ST_RESET   = 2'h0,
        MSRC_ST_COUNT   = 2'h1,
        MSRC_ST_RUN     = 2'h2
    } msrc_state_type;
endpackage

// file: rtl/msrc_sync.sv
// Two-flop synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/1ps
module msrc_sync (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic rst_val,
    input  wire logic d,
    output logic      q
);
    logic meta_r;
    logic meta_nxt;
    logic q_r;
    logic q_nxt;

    always_comb begin
        meta_nxt = d;
        q_nxt    = meta_r;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_r <= rst_val;
            q_r    <= rst_val;
        end else begin
            meta_r <= meta_nxt;
            q_r    <= q_nxt;
        end
    end

    assign q = q_r;
endmodule

// file: rtl/msrc_top.sv
// Mode strap decode and reset control for the U-interface transceiver.
// Assumes straps and reset pin are asynchronous; soft controls come from
// register logic on SYS_CLK.
`timescale 1ns/1ps
`include "msrc_regs.svh"
module msrc_top (
    input  wire logic       SYS_CLK,
    input  wire logic       SRST,
    input  wire logic       RESET_PIN_N,
    input  wire logic       ROLE_SELECT_PIN,
    input  wire logic       HOST_SELECT_PIN,
    input  wire logic       PAR_SELECT_PIN,
    input  wire logic [7:0] SOFT_RESET_REG,
    input  wire logic [7:0] MODE_BYTE8_REG,
    input  wire logic       ROLE_SW_OVERRIDE,
    input  wire logic       TIMING_MASTER,
    input  wire logic [1:0] TDM_FORMAT_SEL,
    input  wire logic       FREQUENCY_REFERENCE_PIN_OUT_EN_REG,
    input  wire logic       LINE_CLK,
    input  wire logic       TDM_BIT_CLOCK_IN,
    input  wire logic       RECEIVE_FRAME_SYNC_IN,
    input  wire logic       FREQUENCY_REFERENCE_PIN_PIN_IN,
    output logic            DEVICE_RESET,
    output logic            REG_DEFAULT_LOAD,
    output logic            NETWORK_TERMINATION_MODE,
    output logic [1:0]      OPERATING_MODE,
    output logic            PARALLEL_PORT_EN,
    output logic            SERIAL_PORT_EN,
    output logic            CONTROL_BUS_MODE,
    output logic            TDM_CONTROL_EN,
    output logic [1:0]      TDM_FORMAT,
    output logic            TDM_BIT_CLOCK_OUT,
    output logic            RECEIVE_FRAME_SYNC_OUT,
    output logic            LINE_DRIVER_TERMINATE,
    output logic            WAKE_TONE_DETECT_EN,
    output logic            FREQUENCY_REFERENCE_PIN_PIN_OUT,
    output logic            FREQUENCY_REFERENCE_PIN_PIN_OE,
    output logic            FREQUENCY_REFERENCE_PIN_8K_IN
);
    //--------------------------------------------------------------------
    // Input synchronisers
    //--------------------------------------------------------------------
    logic rst_n_s;
    logic role_s;
    logic host_s;
    logic par_s;
    logic fref_s;

    msrc_sync u_sync_rst  (.clk(SYS_CLK), .srst(SRST), .rst_val(1'b0), .d(RESET_PIN_N),     .q(rst_n_s)); // RULE_17
    msrc_sync u_sync_role (.clk(SYS_CLK), .srst(SRST), .rst_val(1'b0), .d(ROLE_SELECT_PIN), .q(role_s));  // RULE_17
    msrc_sync u_sync_host (.clk(SYS_CLK), .srst(SRST), .rst_val(1'b0), .d(HOST_SELECT_PIN), .q(host_s));  // RULE_17
    msrc_sync u_sync_par  (.clk(SYS_CLK), .srst(SRST), .rst_val(1'b0), .d(PAR_SELECT_PIN),  .q(par_s));   // RULE_17
    msrc_sync u_sync_fref (.clk(SYS_CLK), .srst(SRST), .rst_val(1'b0), .d(FREQUENCY_REFERENCE_PIN_PIN_IN),  .q(fref_s));

    //--------------------------------------------------------------------
    // Reset sequencer
    //--------------------------------------------------------------------
    localparam int                     RST_MIN_I = `MSRC_RST_MIN_CYC;
    localparam logic [`MSRC_CNT_W-1:0] RST_MIN   = RST_MIN_I[`MSRC_CNT_W-1:0];

    msrc_pkg::msrc_state_type  state_r;
    msrc_pkg::msrc_state_type  state_nxt;
    logic [`MSRC_CNT_W-1:0]    cnt_r;
    logic [`MSRC_CNT_W-1:0]    cnt_nxt;
    logic                      rst_req;

    // Soft reset acts exactly like the pin
    assign rst_req = ~rst_n_s | SOFT_RESET_REG[`MSRC_SOFT_RST_BIT]; // RULE_01 RULE_03

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            msrc_pkg::MSRC_ST_RESET: begin
                cnt_nxt = '0;
                if (rst_req) begin
                    state_nxt = msrc_pkg::MSRC_ST_COUNT;
                end
            end
            msrc_pkg::MSRC_ST_COUNT: begin
                // Even a short glitch counts as a reset; the device stays held for the full minimum regardless
                if (cnt_r < RST_MIN) begin
                    cnt_nxt = cnt_r + 1'b1;
                end
                if (!rst_req && cnt_r >= RST_MIN) begin // RULE_17
                    state_nxt = msrc_pkg::MSRC_ST_RUN;
                end
            end
            msrc_pkg::MSRC_ST_RUN: begin
                cnt_nxt = '0;
                if (rst_req) begin
                    state_nxt = msrc_pkg::MSRC_ST_COUNT;
                end
            end
            default: begin
                state_nxt = msrc_pkg::MSRC_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            state_r <= msrc_pkg::MSRC_ST_RESET;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    //--------------------------------------------------------------------
    // Mode decode and output registers
    //--------------------------------------------------------------------
    logic       in_reset;
    logic       role_nt;
    logic [1:0] mode_sel;
    logic [15:0] out_nxt;
    logic [15:0] out_r;

    assign in_reset = (state_r != msrc_pkg::MSRC_ST_RUN);

    // Software may pick the role instead of the strap
    assign role_nt = ROLE_SW_OVERRIDE ? MODE_BYTE8_REG[`MSRC_ROLE_BIT] : role_s; // RULE_07 RULE_08

    always_comb begin
        // Board is expected to tie parallel select low in bus mode; it is ignored there
        if (!host_s) begin // RULE_09 RULE_11
            mode_sel = msrc_pkg::MSRC_BUS_MODE;
        end else if (par_s) begin // RULE_10
            mode_sel = msrc_pkg::MSRC_HOST_PAR;
        end else begin
            mode_sel = msrc_pkg::MSRC_HOST_SER;
        end
    end

    logic host_m;
    assign host_m = (mode_sel != msrc_pkg::MSRC_BUS_MODE);

    always_comb begin
        out_nxt     = '0;
        out_nxt[0]  = in_reset;                                              // RULE_01
        out_nxt[1]  = in_reset;                                              // RULE_04
        out_nxt[2]  = role_nt;
        out_nxt[4:3] = mode_sel;                                             // RULE_09
        out_nxt[5]  = (mode_sel == msrc_pkg::MSRC_HOST_PAR);                 // RULE_10
        out_nxt[6]  = (mode_sel == msrc_pkg::MSRC_HOST_SER);                 // RULE_10 RULE_14
        out_nxt[7]  = ~host_m;                                               // RULE_14
        out_nxt[8]  = ~host_m;                                               // RULE_12
        out_nxt[10:9] = host_m ? TDM_FORMAT_SEL : `MSRC_FMT_BUS2BD;          // RULE_13
        out_nxt[11] = host_m & TIMING_MASTER & ~in_reset & TDM_BIT_CLOCK_IN; // RULE_05
        out_nxt[12] = host_m & TIMING_MASTER & ~in_reset & RECEIVE_FRAME_SYNC_IN; // RULE_05
        out_nxt[13] = in_reset;                                              // RULE_06
        out_nxt[14] = ~in_reset;                                             // RULE_06
        out_nxt[15] = role_nt & host_m & FREQUENCY_REFERENCE_PIN_OUT_EN_REG;                 // RULE_15 RULE_16
    end

    logic fout_r;
    logic fout_nxt;
    logic fin_r;
    logic fin_nxt;

    always_comb begin
        fout_nxt = out_nxt[15] & LINE_CLK;       // RULE_16
        fin_nxt  = ~role_nt & fref_s;            // RULE_15
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            out_r  <= 16'h2003;
            fout_r <= 1'b0;
            fin_r  <= 1'b0;
        end else begin
            out_r  <= out_nxt;
            fout_r <= fout_nxt;
            fin_r  <= fin_nxt;
        end
    end

    assign DEVICE_RESET             = out_r[0];
    assign REG_DEFAULT_LOAD         = out_r[1];
    assign NETWORK_TERMINATION_MODE = out_r[2];
    assign OPERATING_MODE           = out_r[4:3];
    assign PARALLEL_PORT_EN         = out_r[5];
    assign SERIAL_PORT_EN           = out_r[6];
    assign CONTROL_BUS_MODE         = out_r[7];
    assign TDM_CONTROL_EN           = out_r[8];
    assign TDM_FORMAT               = out_r[10:9];
    assign TDM_BIT_CLOCK_OUT        = out_r[11];
    assign RECEIVE_FRAME_SYNC_OUT   = out_r[12];
    assign LINE_DRIVER_TERMINATE    = out_r[13];
    assign WAKE_TONE_DETECT_EN      = out_r[14];
    assign FREQUENCY_REFERENCE_PIN_PIN_OE           = out_r[15];
    assign FREQUENCY_REFERENCE_PIN_PIN_OUT          = fout_r;
    assign FREQUENCY_REFERENCE_PIN_8K_IN            = fin_r;

    //--------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------
    // Length of the current hold, so the minimum can be checked independently of cnt_r
    logic [`MSRC_CNT_W-1:0] held_r;
    logic [`MSRC_CNT_W-1:0] held_nxt;

    always_comb begin
        held_nxt = held_r;
        if (!in_reset) begin
            held_nxt = '0;
        end else if (held_r != '1) begin
            held_nxt = held_r + 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            held_r <= '0;
        end else begin
            held_r <= held_nxt;
        end
    end

    chk_pin_reset_holds: assert property (@(posedge SYS_CLK) disable iff (SRST)
        !rst_n_s |-> ##[1:2] DEVICE_RESET) else $error("reset pin low did not reset"); // RULE_01
    chk_soft_reset_acts: assert property (@(posedge SYS_CLK) disable iff (SRST)
        SOFT_RESET_REG[`MSRC_SOFT_RST_BIT] |-> ##[1:2] DEVICE_RESET) else $error("soft reset ignored"); // RULE_03
    chk_defaults_load: assert property (@(posedge SYS_CLK) disable iff (SRST)
        DEVICE_RESET |-> REG_DEFAULT_LOAD) else $error("defaults not loaded in reset"); // RULE_04
    chk_clocks_halted: assert property (@(posedge SYS_CLK) disable iff (SRST)
        DEVICE_RESET |-> !TDM_BIT_CLOCK_OUT && !RECEIVE_FRAME_SYNC_OUT) else $error("clock ran in reset"); // RULE_05
    chk_line_terminate: assert property (@(posedge SYS_CLK) disable iff (SRST)
        DEVICE_RESET |-> LINE_DRIVER_TERMINATE && !WAKE_TONE_DETECT_EN) else $error("line not terminated"); // RULE_06
    chk_role_strap: assert property (@(posedge SYS_CLK) disable iff (SRST)
        !ROLE_SW_OVERRIDE && $stable(role_s) |=> NETWORK_TERMINATION_MODE == $past(role_s))
        else $error("role strap wrong"); // RULE_07
    chk_role_soft: assert property (@(posedge SYS_CLK) disable iff (SRST)
        ROLE_SW_OVERRIDE |=> NETWORK_TERMINATION_MODE == $past(MODE_BYTE8_REG[0])) else $error("soft role wrong"); // RULE_08
    chk_mode_decode: assert property (@(posedge SYS_CLK) disable iff (SRST)
        host_s && par_s |=> PARALLEL_PORT_EN && !SERIAL_PORT_EN) else $error("parallel decode wrong"); // RULE_09
    chk_bus_mode: assert property (@(posedge SYS_CLK) disable iff (SRST)
        !host_s |=> CONTROL_BUS_MODE && !SERIAL_PORT_EN && TDM_FORMAT == `MSRC_FMT_BUS2BD)
        else $error("bus mode decode wrong"); // RULE_14
    chk_fref_dir: assert property (@(posedge SYS_CLK) disable iff (SRST)
        !role_nt |=> !FREQUENCY_REFERENCE_PIN_PIN_OE) else $error("reference driven in line mode"); // RULE_15
    chk_min_low: assert property (@(posedge SYS_CLK) disable iff (SRST)
        $fell(in_reset) |-> $past(held_r) >= RST_MIN) else $error("reset shorter than minimum"); // RULE_17

    cov_reset_release: cover property (@(posedge SYS_CLK) disable iff (SRST) $fell(DEVICE_RESET));
    cov_host_par: cover property (@(posedge SYS_CLK) disable iff (SRST) PARALLEL_PORT_EN);
    cov_bus_mode: cover property (@(posedge SYS_CLK) disable iff (SRST) CONTROL_BUS_MODE);
    cov_fref_out: cover property (@(posedge SYS_CLK) disable iff (SRST) FREQUENCY_REFERENCE_PIN_PIN_OE);
endmodule

// file: testbench/msrc_board_model.sv
// Board straps and reset source in front of the mode strap and reset control block.
// Assumes the bench gives strap wishes and a one-cycle reset request on clk.
`timescale 1ns/1ps
module msrc_board_model #(
    parameter int MIN_LOW_CYC = 12
) (
    input  wire logic clk,
    input  wire logic rst_hold,
    input  wire logic role_cmd,
    input  wire logic host_cmd,
    input  wire logic par_cmd,
    output logic      reset_pin_n,
    output logic      role_pin,
    output logic      host_pin,
    output logic      par_pin
);
    logic [3:0] low_cnt_r = 4'h0;
    logic [3:0] low_cnt_nxt;
    // Six oscillator periods are about twelve 40 MHz cycles; a short request is stretched
    always_comb begin
        low_cnt_nxt = low_cnt_r;
        if (rst_hold) begin
            low_cnt_nxt = 4'(MIN_LOW_CYC);
        end else if (low_cnt_r != 4'h0) begin
            low_cnt_nxt = low_cnt_r - 4'h1;
        end
    end
    always_ff @(posedge clk) begin
        low_cnt_r <= low_cnt_nxt;
    end
    assign reset_pin_n = !rst_hold && (low_cnt_r == 4'h0);
    assign role_pin    = role_cmd;
    assign host_pin    = host_cmd;
    assign par_pin     = host_cmd & par_cmd;
endmodule

// file: testbench/mode_strap_and_reset_control_bench.sv
// Self-checking bench for the mode strap and reset control block.
// Assumes msrc_top on one 40 MHz clock and the board model in front of its pins.
`timescale 1ns/1ps
module mode_strap_and_reset_control_bench;
    logic       clk, srst, rst_hold, role_cmd, host_cmd, par_cmd, ovr, mb0, tmaster, oe_en;
    logic       bclk, fsync, line_clk;
    logic [1:0] fmt_sel, fmt, mode;
    logic [7:0] soft_reg;
    wire logic  reset_pin_n, role_pin, host_pin, par_pin;
    logic       dev_rst, def_load, nt, par_en, ser_en, bus, tdm_ctl, bclk_out, fs_out;
    logic       ldt, wake, fref_out, fref_oe, fref_8k, a, b, c;
    int         n_errors, compares;
    // Row: {role,host,par,override,mb0,format,ref_en} then {nt,mode,par_en,ser_en,bus,format,ref_oe}
    localparam logic [16:0] ROWS [5] = '{17'h1C3A1, 17'h08652, 17'h14F0C, 17'h0F9A4, 17'h1AE56};

    msrc_board_model board_u (.clk(clk), .rst_hold(rst_hold), .role_cmd(role_cmd), .host_cmd(host_cmd),
        .par_cmd(par_cmd), .reset_pin_n(reset_pin_n), .role_pin(role_pin), .host_pin(host_pin),
        .par_pin(par_pin));
    msrc_top dut_u (.SYS_CLK(clk), .SRST(srst), .RESET_PIN_N(reset_pin_n), .ROLE_SELECT_PIN(role_pin),
        .HOST_SELECT_PIN(host_pin), .PAR_SELECT_PIN(par_pin), .SOFT_RESET_REG(soft_reg),
        .MODE_BYTE8_REG({7'h2A, mb0}), .ROLE_SW_OVERRIDE(ovr), .TIMING_MASTER(tmaster),
        .TDM_FORMAT_SEL(fmt_sel), .FREQUENCY_REFERENCE_PIN_OUT_EN_REG(oe_en), .LINE_CLK(line_clk),
        .TDM_BIT_CLOCK_IN(bclk), .RECEIVE_FRAME_SYNC_IN(fsync), .FREQUENCY_REFERENCE_PIN_PIN_IN(fsync),
        .DEVICE_RESET(dev_rst), .REG_DEFAULT_LOAD(def_load), .NETWORK_TERMINATION_MODE(nt),
        .OPERATING_MODE(mode), .PARALLEL_PORT_EN(par_en), .SERIAL_PORT_EN(ser_en),
        .CONTROL_BUS_MODE(bus), .TDM_CONTROL_EN(tdm_ctl), .TDM_FORMAT(fmt), .TDM_BIT_CLOCK_OUT(bclk_out),
        .RECEIVE_FRAME_SYNC_OUT(fs_out), .LINE_DRIVER_TERMINATE(ldt), .WAKE_TONE_DETECT_EN(wake),
        .FREQUENCY_REFERENCE_PIN_PIN_OUT(fref_out), .FREQUENCY_REFERENCE_PIN_PIN_OE(fref_oe), .FREQUENCY_REFERENCE_PIN_8K_IN(fref_8k));

    // ------------------------------------------------------------
    // Clock, toggling sources and helpers
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        bclk     <= ~bclk;
        fsync    <= ~fsync;
        line_clk <= ~line_clk;
    end
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic stop_test;
        if (n_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Whole run is about 125 cycles; this leaves ample margin
    initial begin
        #(2000 * 25);
        n_errors++;
        stop_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        n_errors = 0;
        compares = 0;
        {srst, rst_hold, role_cmd, host_cmd, par_cmd, ovr, mb0, oe_en} = 8'h80;
        {bclk, fsync, line_clk, tmaster, fmt_sel, soft_reg} = 14'h0400;
        wait_cyc(10);
        check({5'h00, dev_rst, def_load, ldt, wake}, 9'h00E);
        @(posedge clk) srst <= 1'b0;
        // Release takes fifteen cycles: the count starts at once, so the two sync stages overlap it
        wait_cyc(8);
        check({8'h00, dev_rst}, 9'h001);
        wait_cyc(8);
        check({5'h00, dev_rst, def_load, ldt, wake}, 9'h001);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk) {role_cmd, host_cmd, par_cmd, ovr, mb0, fmt_sel, oe_en} <= ROWS[i][16:9];
            wait_cyc(5);
            check({nt, mode, par_en, ser_en, bus, fmt, fref_oe}, ROWS[i][8:0]);
            check({8'h00, tdm_ctl}, {8'h00, ROWS[i][3]});
            // Toggling sources share one phase; outputs lag them by an odd number of edges
            check({7'h00, fref_out, fref_8k}, {7'h00, ROWS[i][0] & ~line_clk, ~ROWS[i][8] & ~fsync});
        end
        // Host parallel port as timing master: clock, sync and reference output pass while running
        @(posedge clk) {role_cmd, host_cmd, par_cmd, ovr, fmt_sel, oe_en} <= 7'h71;
        wait_cyc(5);
        {a, b, c} = {bclk_out, fs_out, fref_out};
        wait_cyc(1);
        check({6'h00, bclk_out, fs_out, fref_out}, {6'h00, ~a, ~b, ~c});
        // A one-cycle request, stretched by the board, must halt clock and sync
        @(posedge clk) rst_hold <= 1'b1;
        @(posedge clk) rst_hold <= 1'b0;
        wait_cyc(6);
        a = bclk_out;
        b = fs_out;
        check({5'h00, dev_rst, def_load, ldt, wake}, 9'h00E);
        wait_cyc(3);
        check({7'h00, bclk_out, fs_out}, {7'h00, a, b});
        wait_cyc(20);
        check({6'h00, dev_rst, ldt, wake}, 9'h001);
        a = bclk_out;
        wait_cyc(1);
        check({8'h00, bclk_out}, {8'h00, ~a});
        // Every bit but the soft reset bit leaves the device running
        @(posedge clk) soft_reg <= 8'hF7;
        wait_cyc(4);
        check({8'h00, dev_rst}, 9'h000);
        @(posedge clk) soft_reg <= 8'h08;
        wait_cyc(4);
        check({8'h00, dev_rst}, 9'h001);
        @(posedge clk) soft_reg <= 8'h00;
        wait_cyc(6);
        check({8'h00, dev_rst}, 9'h001);
        wait_cyc(10);
        check({8'h00, dev_rst}, 9'h000);
        stop_test();
    end
endmodule
